/* rtl/ccl_noise_filter.sv */
`timescale 1ns/1ps
`default_nettype none

module ccl_noise_filter (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clear,
	input wire logic [1:0] clk_sel,
	input wire logic level_in,
	output logic sample_tick,
	output logic filtered_out
);

	logic [4:0] div_q;
	logic [4:0] div_d;
	logic [ccl_pkg::MATCH_SAMPLES-1:0] samp_q;
	logic [ccl_pkg::MATCH_SAMPLES-1:0] samp_d;
	logic out_q;
	logic out_d;
	logic all_same;
	logic filt_on;

	assign filt_on = clk_sel != ccl_pkg::SYSTEM_CLOCK_OFF;
	// sampling clock as an enable pulse: every cycle, every 8th, every 32nd
	assign sample_tick = (clk_sel == ccl_pkg::SYSTEM_CLOCK_DIV1) ||
		((clk_sel == ccl_pkg::SYSTEM_CLOCK_DIV8) && (div_q[2:0] == ccl_pkg::DIV8_LAST[2:0])) ||
		((clk_sel == ccl_pkg::SYSTEM_CLOCK_DIV32) && (div_q == ccl_pkg::DIV32_LAST));
	assign div_d = clear ? 5'h00 : div_q + 5'h01;
	assign all_same = (samp_q == {ccl_pkg::MATCH_SAMPLES{1'b1}}) || (samp_q == '0);
	// while off the samples track the input so enabling starts from a settled state
	assign samp_d = (!filt_on || sample_tick) ? {samp_q[ccl_pkg::MATCH_SAMPLES-2:0], level_in} : samp_q;
	assign out_d = !filt_on ? level_in :
		(sample_tick && all_same) ? samp_q[0] : out_q;
	assign filtered_out = out_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q <= 5'h00;
			samp_q <= '0;
			out_q <= 1'b0;
		end else if (clear) begin
			div_q <= 5'h00;
			samp_q <= '0;
			out_q <= 1'b0;
		end else begin
			div_q <= div_d;
			samp_q <= samp_d;
			out_q <= out_d;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn || clear);

	property p_filter_change;
		(filt_on && sample_tick && all_same && samp_q[0] != out_q) |=> (out_q == $past(samp_q[0]));
	endproperty
	a_filter_change: assert property (p_filter_change) else $error("filter output missed change");

	property p_filter_needs_three;
		(filt_on && $stable(clk_sel) && $changed(out_q)) |-> $past(all_same && sample_tick);
	endproperty
	a_filter_needs_three: assert property (p_filter_needs_three) else $error("filter changed without three matches");

	property p_div8_spacing;
		(sample_tick && clk_sel == 2'h2) |=> (!sample_tick || clk_sel != 2'h2)[*7];
	endproperty
	a_div8_spacing: assert property (p_div8_spacing) else $error("divide-by-8 tick too early");

	property p_div1_every;
		(clk_sel == 2'h1) |-> sample_tick;
	endproperty
	a_div1_every: assert property (p_div1_every) else $error("undivided tick missing");

	c_filter_change: cover property (filt_on && $changed(out_q));

endmodule

`default_nettype wire

/* rtl/ccl_pkg.sv */
package ccl_pkg;

	// register indices; byte address is four times the index
	localparam logic [19:0] IDX_PERIPHERAL_CLOCK_GATES = 20'hF00F0;
	localparam logic [19:0] IDX_COMPARATOR_MODE_SETTING = 20'hFFF60;
	localparam logic [19:0] IDX_COMPARATOR_FILTER_CONTROL = 20'hFFF61;
	localparam logic [19:0] IDX_COMPARATOR_OUTPUT_CONTROL = 20'hFFF62;

	// values after reset
	localparam logic [7:0] RST_PERIPHERAL_CLOCK_GATES = 8'h00;
	localparam logic [7:0] RST_COMPARATOR_MODE_SETTING = 8'h00;
	localparam logic [7:0] RST_COMPARATOR_FILTER_CONTROL = 8'h00;
	localparam logic [7:0] RST_COMPARATOR_OUTPUT_CONTROL = 8'h00;

	// writable bits; reserved bits read as zero
	localparam logic [7:0] MASK_PERIPHERAL_CLOCK_GATES = 8'hF5;
	localparam logic [7:0] MASK_COMPARATOR_MODE_SETTING = 8'h05;
	localparam logic [7:0] MASK_COMPARATOR_FILTER_CONTROL = 8'h0F;
	localparam logic [7:0] MASK_COMPARATOR_OUTPUT_CONTROL = 8'h87;

	// field positions
	localparam int POS_COMPARATOR_CLOCK_GATE = 5;
	localparam int POS_COMPARE_OPERATION_ENABLE = 0;
	localparam int POS_REFERENCE_SOURCE_SELECT = 2;
	localparam int POS_COMPARE_MONITOR_FLAG = 3;
	localparam int POS_FILTER_CLOCK_SELECT_LO = 0;
	localparam int POS_FILTER_CLOCK_SELECT_HI = 1;
	localparam int POS_EDGE_POLARITY_SELECT = 2;
	localparam int POS_BOTH_EDGE_SELECT = 3;
	localparam int POS_COMPARE_IRQ_ENABLE = 0;
	localparam int POS_RESULT_PIN_OUTPUT_ENABLE = 1;
	localparam int POS_RESULT_PIN_POLARITY = 2;
	localparam int POS_RESPONSE_SPEED_SELECT = 7;

	// filter clock field codes
	localparam logic [1:0] SYSTEM_CLOCK_OFF = 2'h0;
	localparam logic [1:0] SYSTEM_CLOCK_DIV1 = 2'h1;
	localparam logic [1:0] SYSTEM_CLOCK_DIV8 = 2'h2;
	localparam logic [1:0] SYSTEM_CLOCK_DIV32 = 2'h3;

	// divider terminal counts and matching samples
	localparam logic [4:0] DIV8_LAST = 5'h07;
	localparam logic [4:0] DIV32_LAST = 5'h1F;
	localparam int MATCH_SAMPLES = 3;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

endpackage

/* rtl/ccl_top.sv */
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - gate bit low holds comparator in reset, clears and locks its registers
// - mode register bit 3 reads the comparison result, read only
// - monitor flag means something only while operation is enabled
// - reference select: 0 external pin, 1 internal reference
// - mode bit 0 enables comparator operation
// - filter accepts a level after three identical consecutive samples
// - filter clock field: off, undivided, divide by 8, divide by 32
// - edge select: rising, falling, or both when both-edge bit set
// - output control bit 7 selects low or high response speed
// - result pin polarity bit inverts the result when set
// - result pin output enable drives the result onto the pin
// - interrupt enable bit gates the interrupt request
// - selected effective edge of the comparator output raises the request
// - all four registers reset to zero
// - filter output changes at the sampling edge after three matches
module ccl_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic comparator_raw,
	output logic comparator_reset_n,
	output logic compare_operation_enable,
	output logic reference_source_select,
	output logic response_speed_select,
	output logic result_output_pin,
	output logic result_output_pin_oe,
	output logic compare_irq_request
);

	// ---- bus slave: zero wait states, always OKAY
	logic addr_ok;
	logic rd_accept;
	logic wr_accept;
	logic [19:0] addr_idx;
	logic wr_pend_q;
	logic [19:0] wr_idx_q;
	logic [31:0] hrdata_q;
	logic [31:0] rd_next;
	logic [7:0] wdat;

	// registers
	logic [7:0] per_q;
	logic [7:0] per_d;
	logic [7:0] mode_q;
	logic [7:0] mode_d;
	logic [7:0] filt_q;
	logic [7:0] filt_d;
	logic [7:0] outc_q;
	logic [7:0] outc_d;
	logic gate_on;
	logic wr_per;
	logic wr_mode;
	logic wr_filt;
	logic wr_outc;

	// comparator path
	logic raw_meta_q;
	logic raw_sync_q;
	logic filt_level;
	logic filt_on;
	logic level;
	logic level_prev_q;
	logic rise;
	logic fall;
	logic edge_hit;
	logic monitor;
	logic irq_q;
	logic pin_q;
	logic [7:0] mode_rd;

	assign addr_ok = hsel && hready && (htrans == ccl_pkg::HTRANS_NONSEQ || htrans == 2'h3);
	assign rd_accept = addr_ok && !hwrite;
	assign wr_accept = addr_ok && hwrite;
	// upper address bits beyond the index field must be zero to hit a register
	assign addr_idx = (haddr[31:22] == 10'h000) ? haddr[21:2] : 20'h00000;
	assign wdat = hwdata[7:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_idx_q <= 20'h00000;
		end else begin
			wr_pend_q <= wr_accept;
			wr_idx_q <= addr_idx;
		end
	end

	// ---- register writes in the data phase
	assign gate_on = per_q[ccl_pkg::POS_COMPARATOR_CLOCK_GATE];
	assign wr_per = wr_pend_q && (wr_idx_q == ccl_pkg::IDX_PERIPHERAL_CLOCK_GATES);
	assign wr_mode = wr_pend_q && (wr_idx_q == ccl_pkg::IDX_COMPARATOR_MODE_SETTING);
	assign wr_filt = wr_pend_q && (wr_idx_q == ccl_pkg::IDX_COMPARATOR_FILTER_CONTROL);
	assign wr_outc = wr_pend_q && (wr_idx_q == ccl_pkg::IDX_COMPARATOR_OUTPUT_CONTROL);

	// reserved bits are masked off so a stray one never sticks
	assign per_d = wr_per ? (wdat & ccl_pkg::MASK_PERIPHERAL_CLOCK_GATES) : per_q;
	// gate low: registers pinned to reset value, writes dropped
	assign mode_d = !gate_on ? ccl_pkg::RST_COMPARATOR_MODE_SETTING :
		wr_mode ? (wdat & ccl_pkg::MASK_COMPARATOR_MODE_SETTING) : mode_q;
	assign filt_d = !gate_on ? ccl_pkg::RST_COMPARATOR_FILTER_CONTROL :
		wr_filt ? (wdat & ccl_pkg::MASK_COMPARATOR_FILTER_CONTROL) : filt_q;
	assign outc_d = !gate_on ? ccl_pkg::RST_COMPARATOR_OUTPUT_CONTROL :
		wr_outc ? (wdat & ccl_pkg::MASK_COMPARATOR_OUTPUT_CONTROL) : outc_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			per_q <= ccl_pkg::RST_PERIPHERAL_CLOCK_GATES;
			mode_q <= ccl_pkg::RST_COMPARATOR_MODE_SETTING;
			filt_q <= ccl_pkg::RST_COMPARATOR_FILTER_CONTROL;
			outc_q <= ccl_pkg::RST_COMPARATOR_OUTPUT_CONTROL;
		end else begin
			per_q <= per_d;
			mode_q <= mode_d;
			filt_q <= filt_d;
			outc_q <= outc_d;
		end
	end

	// ---- read data; uses next values so a read right after a write sees it
	// disabled comparator reads the monitor as zero rather than stale data
	assign monitor = mode_d[ccl_pkg::POS_COMPARE_OPERATION_ENABLE] && raw_sync_q;
	assign mode_rd = {mode_d[7:4], monitor, mode_d[2:0]};
	assign rd_next = (addr_idx == ccl_pkg::IDX_PERIPHERAL_CLOCK_GATES) ? {24'h000000, per_d} :
		(addr_idx == ccl_pkg::IDX_COMPARATOR_MODE_SETTING) ? {24'h000000, mode_rd} :
		(addr_idx == ccl_pkg::IDX_COMPARATOR_FILTER_CONTROL) ? {24'h000000, filt_d} :
		(addr_idx == ccl_pkg::IDX_COMPARATOR_OUTPUT_CONTROL) ? {24'h000000, outc_d} :
		32'h00000000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h00000000;
		end else if (rd_accept) begin
			hrdata_q <= rd_next;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = 1'b1;
	assign hresp = ccl_pkg::HRESP_OKAY;

	// ---- analog controls straight from register bits
	assign comparator_reset_n = gate_on;
	assign compare_operation_enable = mode_q[ccl_pkg::POS_COMPARE_OPERATION_ENABLE];
	assign reference_source_select = mode_q[ccl_pkg::POS_REFERENCE_SOURCE_SELECT];
	assign response_speed_select = outc_q[ccl_pkg::POS_RESPONSE_SPEED_SELECT];

	// ---- comparator output: synchroniser, filter, edge detector
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			raw_meta_q <= 1'b0;
			raw_sync_q <= 1'b0;
		end else begin
			raw_meta_q <= comparator_raw;
			raw_sync_q <= raw_meta_q;
		end
	end

	ccl_noise_filter u_filter (
		.hclk(hclk),
		.hresetn(hresetn),
		.clear(!gate_on),
		.clk_sel(filt_q[ccl_pkg::POS_FILTER_CLOCK_SELECT_HI:ccl_pkg::POS_FILTER_CLOCK_SELECT_LO]),
		.level_in(raw_sync_q),
		.sample_tick(),
		.filtered_out(filt_level)
	);

	assign filt_on = filt_q[ccl_pkg::POS_FILTER_CLOCK_SELECT_HI:ccl_pkg::POS_FILTER_CLOCK_SELECT_LO]
		!= ccl_pkg::SYSTEM_CLOCK_OFF;
	// bypass uses the synchronised level directly, saving the filter's cycle
	assign level = filt_on ? filt_level : raw_sync_q;
	assign rise = level && !level_prev_q;
	assign fall = !level && level_prev_q;
	assign edge_hit = filt_q[ccl_pkg::POS_BOTH_EDGE_SELECT] ? (rise || fall) :
		(filt_q[ccl_pkg::POS_EDGE_POLARITY_SELECT] ? fall : rise);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			level_prev_q <= 1'b0;
			irq_q <= 1'b0;
			pin_q <= 1'b0;
		end else begin
			level_prev_q <= level;
			// one pulse per qualifying edge, only while operating and enabled
			irq_q <= edge_hit && mode_q[ccl_pkg::POS_COMPARE_OPERATION_ENABLE] &&
				outc_q[ccl_pkg::POS_COMPARE_IRQ_ENABLE];
			pin_q <= outc_q[ccl_pkg::POS_RESULT_PIN_OUTPUT_ENABLE] &&
				(level ^ outc_q[ccl_pkg::POS_RESULT_PIN_POLARITY]);
		end
	end

	assign compare_irq_request = irq_q;
	assign result_output_pin = pin_q;
	assign result_output_pin_oe = outc_q[ccl_pkg::POS_RESULT_PIN_OUTPUT_ENABLE];

	// ---- checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_gate_locks;
		(!gate_on && wr_pend_q) |=> (mode_q == 8'h00 && filt_q == 8'h00 && outc_q == 8'h00);
	endproperty
	a_gate_locks: assert property (p_gate_locks) else $error("registers not cleared while gate off");

	property p_monitor_read;
		(rd_accept && addr_idx == 20'hFFF60) |=>
			(hrdata[3] == ($past(raw_sync_q) && $past(mode_d[0])));
	endproperty
	a_monitor_read: assert property (p_monitor_read) else $error("monitor flag wrong");

	property p_ref_select;
		(wr_pend_q && wr_idx_q == 20'hFFF60 && gate_on) |=>
			(reference_source_select == $past(hwdata[2]) && compare_operation_enable == $past(hwdata[0]));
	endproperty
	a_ref_select: assert property (p_ref_select) else $error("mode write not applied");

	property p_speed_select;
		(wr_pend_q && wr_idx_q == 20'hFFF62 && gate_on) |=> (response_speed_select == $past(hwdata[7]));
	endproperty
	a_speed_select: assert property (p_speed_select) else $error("speed select not applied");

	property p_irq_gated;
		compare_irq_request |-> ($past(outc_q[0]) && $past(mode_q[0]));
	endproperty
	a_irq_gated: assert property (p_irq_gated) else $error("request while disabled");

	property p_irq_rise;
		(rise && mode_q[0] && outc_q[0] && filt_q[3:2] == 2'h0) |=> compare_irq_request;
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("rising edge lost");

	property p_irq_edge_kind;
		(compare_irq_request && $past(filt_q[3:2]) == 2'h1) |-> $past(fall);
	endproperty
	a_irq_edge_kind: assert property (p_irq_edge_kind) else $error("falling mode fired on wrong edge");

	// a second raw change right behind the first legitimately gives a second pulse
	property p_bypass_edge;
		(filt_q[1:0] == 2'h0 && $stable(filt_q) && filt_q[3] && mode_q[0] && outc_q[0] && $changed(raw_sync_q))
			|=> compare_irq_request and (($stable(raw_sync_q) && $stable(filt_q)) |=> !compare_irq_request);
	endproperty
	a_bypass_edge: assert property (p_bypass_edge) else $error("unfiltered edge not one pulse");

	property p_pin_value;
		1'b1 |=> (result_output_pin == ($past(outc_q[1]) && ($past(level) ^ $past(outc_q[2]))));
	endproperty
	a_pin_value: assert property (p_pin_value) else $error("result pin value wrong");

	property p_pin_off;
		!outc_q[1] |=> !result_output_pin;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("result pin driven while disabled");

	property p_reset_values;
		$rose(hresetn) |-> (per_q == ccl_pkg::RST_PERIPHERAL_CLOCK_GATES
			&& mode_q == ccl_pkg::RST_COMPARATOR_MODE_SETTING
			&& filt_q == ccl_pkg::RST_COMPARATOR_FILTER_CONTROL
			&& outc_q == ccl_pkg::RST_COMPARATOR_OUTPUT_CONTROL
			&& hrdata == 32'h00000000 && !compare_irq_request);
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("register not at reset value");

	property p_monitor_off;
		(rd_accept && addr_idx == ccl_pkg::IDX_COMPARATOR_MODE_SETTING && !mode_d[0]) |=> !hrdata[3];
	endproperty
	a_monitor_off: assert property (p_monitor_off) else $error("monitor flag set while disabled");

	property p_oe_write;
		(wr_pend_q && wr_idx_q == ccl_pkg::IDX_COMPARATOR_OUTPUT_CONTROL && gate_on) |=>
			(result_output_pin_oe == $past(hwdata[1]));
	endproperty
	a_oe_write: assert property (p_oe_write) else $error("pin enable write not applied");

	property p_gate_write;
		(wr_pend_q && wr_idx_q == ccl_pkg::IDX_PERIPHERAL_CLOCK_GATES) |=>
			(comparator_reset_n == $past(hwdata[5]));
	endproperty
	a_gate_write: assert property (p_gate_write) else $error("reset control not following gate bit");

	property p_fall_mode;
		(fall && mode_q[0] && outc_q[0] && filt_q[3:2] == 2'h1) |=> compare_irq_request;
	endproperty
	a_fall_mode: assert property (p_fall_mode) else $error("falling edge lost");

	property p_both_mode;
		((rise || fall) && mode_q[0] && outc_q[0] && filt_q[3]) |=> compare_irq_request;
	endproperty
	a_both_mode: assert property (p_both_mode) else $error("edge lost in both-edge mode");

	property p_rise_only;
		(compare_irq_request && $past(filt_q[3:2]) == 2'h0) |-> $past(rise);
	endproperty
	a_rise_only: assert property (p_rise_only) else $error("rising mode fired on wrong edge");

	property p_filter_clear;
		!gate_on |=> !filt_level;
	endproperty
	a_filter_clear: assert property (p_filter_clear) else $error("filter not cleared while gate off");

	property p_pin_invert;
		(outc_q[1] && outc_q[2]) |=> (result_output_pin == !$past(level));
	endproperty
	a_pin_invert: assert property (p_pin_invert) else $error("inverted pin value wrong");

	property p_irq_off;
		!outc_q[0] |=> !compare_irq_request;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("request with interrupt enable clear");

	property p_gated_read;
		(rd_accept && !gate_on && addr_idx != ccl_pkg::IDX_PERIPHERAL_CLOCK_GATES) |=>
			(hrdata == 32'h00000000);
	endproperty
	a_gated_read: assert property (p_gated_read) else $error("gated register reads nonzero");

	property p_monitor_ro;
		(wr_pend_q && wr_idx_q == ccl_pkg::IDX_COMPARATOR_MODE_SETTING) |=> !mode_q[3];
	endproperty
	a_monitor_ro: assert property (p_monitor_ro) else $error("monitor bit took a write");

	property p_gate_off_outputs;
		!gate_on |=> (!result_output_pin_oe && !compare_operation_enable);
	endproperty
	a_gate_off_outputs: assert property (p_gate_off_outputs) else $error("controls active while gate off");

	c_irq: cover property (compare_irq_request);
	c_both_edges: cover property (filt_q[3] && compare_irq_request ##[1:50] compare_irq_request);
	c_monitor_high: cover property (rd_accept && addr_idx == 20'hFFF60 ##1 hrdata[3]);
	c_filtered_irq: cover property (filt_on && compare_irq_request);

endmodule

`default_nettype wire

/* sim/ccl_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none

module ccl_analog_model #(
	parameter logic [7:0] INT_REF = 8'hC0
) (
	input wire logic hclk,
	input wire logic [7:0] analog_input_pin,
	input wire logic [7:0] external_reference_pin,
	input wire logic reference_source_select,
	input wire logic comparator_reset_n,
	input wire logic compare_operation_enable,
	output logic comparator_raw
);
	logic junk_q = 1'b0;
	logic [7:0] ref_level;
	// an idle comparator has no stable answer, so show a moving pattern
	always @(posedge hclk) begin
		junk_q <= ~junk_q;
	end
	assign ref_level = reference_source_select ? INT_REF : external_reference_pin;
	assign comparator_raw = (comparator_reset_n && compare_operation_enable) ?
		(analog_input_pin > ref_level) : junk_q;
endmodule

`default_nettype wire

/* sim/test_comparator_control_logic.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("wrong value at %0t: %h expected %h", $time, a, b); end end

module test_comparator_control_logic;
	localparam logic [19:0] G = ccl_pkg::IDX_PERIPHERAL_CLOCK_GATES;
	localparam logic [19:0] M = ccl_pkg::IDX_COMPARATOR_MODE_SETTING;
	localparam logic [19:0] F = ccl_pkg::IDX_COMPARATOR_FILTER_CONTROL;
	localparam logic [19:0] O = ccl_pkg::IDX_COMPARATOR_OUTPUT_CONTROL;
	logic hclk = 1'b0;
	logic hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic raw, rst_n, op_en, ref_sel, speed, pin, pin_oe, irq;
	logic [7:0] ain, eref;
	int mismatches = 0;
	int num_checks = 0;

	assign hready = hreadyout;
	always #2.5 hclk = ~hclk;

	ccl_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .comparator_raw(raw), .comparator_reset_n(rst_n),
		.compare_operation_enable(op_en), .reference_source_select(ref_sel),
		.response_speed_select(speed), .result_output_pin(pin), .result_output_pin_oe(pin_oe),
		.compare_irq_request(irq));

	ccl_analog_model analog (.hclk(hclk), .analog_input_pin(ain), .external_reference_pin(eref),
		.reference_source_select(ref_sel), .comparator_reset_n(rst_n),
		.compare_operation_enable(op_en), .comparator_raw(raw));

	task automatic bus(input logic wr, input logic [19:0] i, input logic [7:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {10'h000, i, 2'b00};
		hwrite <= wr;
		htrans <= ccl_pkg::HTRANS_NONSEQ;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {24'h000000, d};
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
		`CHK(hresp, ccl_pkg::HRESP_OKAY)
	endtask

	task automatic wr(input logic [19:0] i, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, i, d, r);
	endtask

	task automatic rc(input logic [19:0] i, input logic [7:0] e);
		logic [31:0] r;
		bus(1'b0, i, 8'h00, r);
		`CHK(r, {24'h000000, e})
	endtask

	task automatic set_in(input logic [7:0] a);
		@(posedge hclk);
		ain <= a;
	endtask

	task automatic cnt(input int n, output int c);
		c = 0;
		repeat (n) begin
			@(posedge hclk);
			#1;
			if (irq === 1'b1) c++;
		end
	endtask

	task automatic t_reset_and_lock;
		rc(G, 8'h00);
		rc(M, 8'h00);
		rc(F, 8'h00);
		rc(O, 8'h00);
		rc(20'h00010, 8'h00);
		wr(M, 8'h05);
		wr(O, 8'h87);
		rc(M, 8'h00);
		rc(O, 8'h00);
		`CHK({rst_n, op_en, speed, pin_oe}, 4'h0)
		wr(G, 8'hF5);
		rc(G, 8'hF5);
		wr(G, 8'h20);
		@(posedge hclk);
		`CHK(rst_n, 1'b1)
	endtask

	task automatic t_mode_and_pin;
		eref <= 8'h64;
		set_in(8'hC8);
		wr(M, 8'h01);
		repeat (4) @(posedge hclk);
		rc(M, 8'h09);
		`CHK({op_en, ref_sel}, 2'b10)
		wr(M, 8'h05);
		repeat (4) @(posedge hclk);
		rc(M, 8'h0D);
		`CHK(ref_sel, 1'b1)
		wr(O, 8'h06);
		repeat (4) @(posedge hclk);
		`CHK({pin_oe, pin, speed}, 3'b100)
		wr(M, 8'h01);
		wr(O, 8'h02);
		repeat (4) @(posedge hclk);
		`CHK({pin_oe, pin}, 2'b11)
		wr(M, 8'h00);
		wr(O, 8'h80);
		repeat (2) @(posedge hclk);
		`CHK({pin_oe, pin, speed}, 3'b001)
		rc(O, 8'h80);
		wr(M, 8'h01);
	endtask

	task automatic t_edges;
		logic [7:0] codes [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
		int c;
		foreach (codes[k]) begin
			wr(O, 8'h80);
			set_in(8'h32);
			wr(F, codes[k]);
			repeat (8) @(posedge hclk);
			wr(O, 8'h81);
			set_in(8'hC8);
			cnt(10, c);
			`CHK(c, (codes[k] == 8'h04) ? 0 : 1)
			set_in(8'h32);
			cnt(10, c);
			`CHK(c, (codes[k] == 8'h00) ? 0 : 1)
		end
		wr(O, 8'h80);
		set_in(8'hC8);
		cnt(10, c);
		`CHK(c, 0)
	endtask

	task automatic t_filter;
		int div [4] = '{1, 1, 8, 32};
		int c;
		for (int k = 0; k < 4; k++) begin
			wr(O, 8'h80);
			set_in(8'h32);
			wr(F, k[7:0]);
			repeat (4 * div[k] + 8) @(posedge hclk);
			wr(O, 8'h81);
			set_in(8'hC8);
			repeat (2 * div[k] - 1) @(posedge hclk);
			ain <= 8'h32;
			cnt(4 * div[k] + 10, c);
			`CHK(c, (k == 0) ? 1 : 0)
			set_in(8'hC8);
			c = 0;
			while (irq !== 1'b1 && c < 400) begin
				@(posedge hclk);
				#1;
				c++;
			end
			if (k == 0) `CHK(c, 3)
			else `CHK(c >= 2 * div[k] && c <= 4 * div[k] + 4, 1'b1)
		end
		wr(F, 8'h00);
		wr(G, 8'h00);
		rc(F, 8'h00);
		`CHK({rst_n, irq}, 2'b00)
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge hclk);
		mismatches++;
		conclude();
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		ain = 8'h00;
		eref = 8'h64;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset_and_lock();
		t_mode_and_pin();
		t_edges();
		t_filter();
		conclude();
	end
endmodule

`default_nettype wire
